/* include/dspd_pkg.sv */
// dspd_pkg: constants and types of the dual-section panel receive logic.
// assumes one 100 MHz system clock and a slower shift clock from the controller.
`default_nettype none

package dspd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// panel geometry
	localparam int PIXELS_PER_ROW = 320;
	localparam int SUBPIX_PER_PIXEL = 3;
	localparam int ROWS_PER_FRAME = 240;
	localparam int BUS_WIDTH = 8;
	localparam int NIBBLE_WIDTH = 4;
	localparam int COL_W = 8;
	localparam int ROW_W = 8;
	localparam int SUBPIX_PER_ROW = PIXELS_PER_ROW * SUBPIX_PER_PIXEL;
	localparam logic [COL_W-1:0] WORDS_8BIT = COL_W'(SUBPIX_PER_ROW / BUS_WIDTH);
	localparam logic [COL_W-1:0] WORDS_4BIT = COL_W'(SUBPIX_PER_ROW / NIBBLE_WIDTH);
	localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(ROWS_PER_FRAME - 1);
	// low nibble of each half kept in four-bit mode
	localparam logic [2*BUS_WIDTH-1:0] MASK_4BIT = 16'h0F0F;

	////////////////////////////////////////////////////////////////////////////
	// buffering and crossing
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 2 * BUS_WIDTH;
	localparam int SYNC_STAGES = 2;
	localparam int PIN_COUNT = 7;
	localparam int PIN_LINE = 0;
	localparam int PIN_FRAME = 1;
	localparam int PIN_ALT = 2;
	localparam int PIN_DISP = 3;
	localparam int PIN_MODE = 4;
	localparam int PIN_SEL = 5;
	localparam int PIN_OVF = 6;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int SYS_CLK_PERIOD_PS = 10_000;
	localparam int T_SHIFT_TO_LINE_NS = 30;
	localparam int GUARD_CYC =
		(T_SHIFT_TO_LINE_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
	localparam int DRAIN_MAX_CYC = 64;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [ROW_W-1:0] ROW_FIRST = 8'h00;
	localparam logic [COL_W-1:0] COL_RESET = 8'h00;
	localparam logic [ROW_W-1:0] LINE_CNT_RESET = ROW_W'(ROWS_PER_FRAME);
	localparam logic [3:0] GUARD_RESET = 4'h0;
	localparam logic [6:0] AGE_RESET = 7'h00;
	localparam logic [1:0] CAP_RESET = 2'h0;

	typedef enum logic [0:0] {
		ST_SHIFT = 1'b0,
		ST_DRAIN = 1'b1
	} dspd_state_type;

endpackage : dspd_pkg

`default_nettype wire

/* verilog/dspd_sync2.sv */
// dspd_sync2: two-flop level synchroniser, one lane per bit.
// assumes inputs are levels that hold for several destination clocks.
`default_nettype none

module dspd_sync2 #(
	parameter int WIDTH = 1
) (
	// destination clock domain
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else if (en) begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;

endmodule : dspd_sync2

`default_nettype wire

/* verilog/dspd_fifo.sv */
// dspd_fifo: dual-clock word FIFO with gray-coded pointers.
// assumes DEPTH is a power of two, at least four.
`default_nettype none

module dspd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// write side
	input wire logic wr_clk,
	input wire logic wr_rst,
	input wire logic wr_valid,
	input wire logic [WIDTH-1:0] wr_data,
	output logic wr_ready,
	// read side
	input wire logic rd_clk,
	input wire logic rd_rst,
	input wire logic rd_en,
	input wire logic rd_ready,
	output logic rd_valid,
	output logic [WIDTH-1:0] rd_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0] wbin_reg;
	logic [AW:0] wgray_reg;
	logic [AW:0] rbin_reg;
	logic [AW:0] rgray_reg;
	logic [AW:0] wbin_next;
	logic [AW:0] rbin_next;
	logic [AW:0] wgray_rd;
	logic [AW:0] rgray_wr;
	logic push;
	logic pop;

	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready && rd_en;
	assign wbin_next = wbin_reg + (AW+1)'(1);
	assign rbin_next = rbin_reg + (AW+1)'(1);

	////////////////////////////////////////////////////////////////////////////
	// write domain
	always_ff @(posedge wr_clk or posedge wr_rst) begin
		if (wr_rst) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
		end else if (push) begin
			wbin_reg <= wbin_next;
			wgray_reg <= wbin_next ^ (wbin_next >> 1);
		end
	end

	always_ff @(posedge wr_clk) begin
		if (push) begin
			mem[wbin_reg[AW-1:0]] <= wr_data;
		end
	end

	dspd_sync2 #(.WIDTH(AW + 1)) u_rptr_sync (
		.clk(wr_clk),
		.rst(wr_rst),
		.en(1'b1),
		.d(rgray_reg),
		.q(rgray_wr)
	);

	// full when the write pointer is a whole lap ahead
	assign wr_ready = wgray_reg != {~rgray_wr[AW:AW-1], rgray_wr[AW-2:0]};

	////////////////////////////////////////////////////////////////////////////
	// read domain
	always_ff @(posedge rd_clk or posedge rd_rst) begin
		if (rd_rst) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
		end else if (pop) begin
			rbin_reg <= rbin_next;
			rgray_reg <= rbin_next ^ (rbin_next >> 1);
		end
	end

	dspd_sync2 #(.WIDTH(AW + 1)) u_wptr_sync (
		.clk(rd_clk),
		.rst(rd_rst),
		.en(rd_en),
		.d(wgray_reg),
		.q(wgray_rd)
	);

	assign rd_valid = rgray_reg != wgray_rd;
	assign rd_data = mem[rbin_reg[AW-1:0]];

endmodule : dspd_fifo

`default_nettype wire

/* verilog/dspd_panel.sv */
// dspd_panel: receive logic of a dual-section passive colour panel.
// assumes a controller drives shift, line and frame clocks plus two data buses.
// Function
// RL1: image grid is 320 RGB pixels by 240 rows; each line must fill it.
// RL2: one-in-240 scan; each frame runs the full row count before next start.
// RL3: controller sends two parallel buses, 4 or 8 bits, alternating order.
// RL4: one bus loads the upper half, the other the lower, same line period.
// RL5: internal alternation generator; an external alternation input may replace it.
// RL6: external alternation must toggle within and across every frame.
// RL7: controller paces frame starts near 73 Hz.
// RL8: power-up order control, logic supply, drive supply; reverse at power-down.
// RL9: frame start syncs scan, line clock latches row, shift clock loads words.
// RL10: each bus bit carries subpixels in a fixed controller-ordered rotation.
// RL11: strap picks 8- or 4-bit buses; 4-bit mode ignores upper bits.
// RL12: display enable high shows the image, low blanks it.
// RL13: frame start brackets first row line clock; line clock after last shift.
// RL14: external alternation changes only near line clock edges.
`default_nettype none

module dspd_panel
	import dspd_pkg::*;
(
	// system domain
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	// link pins
	input wire logic pixel_shift_clock,
	input wire logic [BUS_WIDTH-1:0] upper_half_data_bus,
	input wire logic [BUS_WIDTH-1:0] lower_half_data_bus,
	input wire logic line_latch_clock,
	input wire logic frame_start_pulse,
	input wire logic alternation_pin,
	input wire logic alt_external_sel,
	input wire logic bus_mode_8bit,
	input wire logic display_enable_pin,
	// link flow control
	output logic shift_ready,
	// latched row readout
	input wire logic [COL_W-1:0] rd_addr,
	output logic [BUS_WIDTH-1:0] rd_upper,
	output logic [BUS_WIDTH-1:0] rd_lower,
	// scan status
	output logic [ROW_W-1:0] scan_row,
	output logic row_strobe,
	output logic frame_strobe,
	output logic drive_polarity,
	output logic display_on,
	output logic mode_8bit,
	output logic grid_error,
	output logic alt_fault,
	output logic overrun
);

	////////////////////////////////////////////////////////////////////////////
	// link domain: words enter on the shift clock
	logic link_rst_meta_reg;
	logic link_rst_reg;
	logic ov_tgl_reg;
	logic ov_armed_reg;
	logic fifo_wr_ready;

	always_ff @(posedge pixel_shift_clock or posedge reset) begin
		if (reset) begin
			link_rst_meta_reg <= 1'b1;
			link_rst_reg <= 1'b1;
		end else begin
			link_rst_meta_reg <= 1'b0;
			link_rst_reg <= link_rst_meta_reg;
		end
	end

	// panel pins cannot stall, so a full buffer is reported as an event
	// one toggle per full episode: an even count would vanish behind a frozen sync
	always_ff @(posedge pixel_shift_clock or posedge link_rst_reg) begin
		if (link_rst_reg) begin
			ov_tgl_reg <= 1'b0;
			ov_armed_reg <= 1'b1;
		end else begin
			ov_armed_reg <= fifo_wr_ready;
			if (!fifo_wr_ready && ov_armed_reg) begin
				ov_tgl_reg <= ~ov_tgl_reg;
			end
		end
	end

	assign shift_ready = fifo_wr_ready;

	logic fifo_valid;
	logic [FIFO_WIDTH-1:0] fifo_data;

	dspd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.wr_clk(pixel_shift_clock),
		.wr_rst(link_rst_reg),
		.wr_valid(!link_rst_reg),
		.wr_data({upper_half_data_bus, lower_half_data_bus}), // see RL4
		.wr_ready(fifo_wr_ready),
		.rd_clk(sys_clk),
		.rd_rst(reset),
		.rd_en(clk_en),
		.rd_ready(1'b1),
		.rd_valid(fifo_valid),
		.rd_data(fifo_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_sync;

	assign pin_raw = {ov_tgl_reg, alt_external_sel, bus_mode_8bit, display_enable_pin,
		alternation_pin, frame_start_pulse, line_latch_clock};

	dspd_sync2 #(.WIDTH(PIN_COUNT)) u_pin_sync (
		.clk(sys_clk),
		.rst(reset),
		.en(clk_en),
		.d(pin_raw),
		.q(pin_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// strap capture after reset release
	logic [1:0] cap_cnt_reg;
	logic mode_cap_reg;
	logic mode_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cap_cnt_reg <= CAP_RESET;
			mode_cap_reg <= 1'b0;
			mode_reg <= 1'b0;
		end else if (clk_en && !mode_cap_reg) begin
			cap_cnt_reg <= cap_cnt_reg + 2'h1;
			if (cap_cnt_reg == 2'(SYNC_STAGES)) begin
				mode_reg <= pin_sync[PIN_MODE]; // see RL11
				mode_cap_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// line sequencing
	dspd_state_type state_reg;
	logic line_prev_reg;
	logic frame_at_line_reg;
	logic [3:0] guard_reg;
	logic [6:0] drain_age_reg;
	logic line_rise;
	logic commit;
	logic frame_commit;

	assign line_rise = pin_sync[PIN_LINE] && !line_prev_reg;
	// line clock follows the last shift; wait for the buffer to stay empty
	assign commit = clk_en && state_reg == ST_DRAIN && !fifo_valid
		&& guard_reg == 4'(GUARD_CYC - 1); // see RL13
	assign frame_commit = commit && frame_at_line_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_SHIFT;
			line_prev_reg <= 1'b0;
			frame_at_line_reg <= 1'b0;
			guard_reg <= GUARD_RESET;
			drain_age_reg <= AGE_RESET;
		end else if (clk_en) begin
			line_prev_reg <= pin_sync[PIN_LINE];
			case (state_reg)
				ST_SHIFT: begin
					guard_reg <= GUARD_RESET;
					drain_age_reg <= AGE_RESET;
					if (line_rise) begin
						state_reg <= ST_DRAIN; // see RL9
						frame_at_line_reg <= pin_sync[PIN_FRAME]; // see RL13
					end
				end
				ST_DRAIN: begin
					drain_age_reg <= drain_age_reg + 7'h01;
					guard_reg <= fifo_valid ? GUARD_RESET : guard_reg + 4'h1;
					if (commit) begin
						state_reg <= ST_SHIFT;
					end
				end
				default: begin
					state_reg <= ST_SHIFT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// row store: two banks, one filling while the other is read
	logic [FIFO_WIDTH-1:0] row_mem [0:1][0:WORDS_4BIT-1];
	logic bank_reg;
	logic [COL_W-1:0] col_reg;
	logic [FIFO_WIDTH-1:0] wr_word;
	logic pop;
	logic [COL_W-1:0] words_exp;

	assign pop = clk_en && fifo_valid;
	assign wr_word = mode_reg ? fifo_data : fifo_data & MASK_4BIT; // see RL11
	assign words_exp = mode_reg ? WORDS_8BIT : WORDS_4BIT;

	always_ff @(posedge sys_clk) begin
		if (pop && col_reg < WORDS_4BIT) begin
			row_mem[bank_reg][col_reg] <= wr_word; // see RL9
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			col_reg <= COL_RESET;
			bank_reg <= 1'b0;
		end else if (commit) begin
			col_reg <= COL_RESET;
			bank_reg <= ~bank_reg; // see RL4
		end else if (pop && col_reg != 8'hFF) begin
			col_reg <= col_reg + 8'h01;
		end
	end

	logic [BUS_WIDTH-1:0] rd_upper_reg;
	logic [BUS_WIDTH-1:0] rd_lower_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rd_upper_reg <= 8'h00;
			rd_lower_reg <= 8'h00;
		end else if (clk_en) begin
			if (rd_addr < WORDS_4BIT) begin
				{rd_upper_reg, rd_lower_reg} <= row_mem[~bank_reg][rd_addr];
			end else begin
				{rd_upper_reg, rd_lower_reg} <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scan counters and grid check
	logic [ROW_W-1:0] row_reg;
	logic [ROW_W-1:0] line_cnt_reg;
	logic row_strobe_reg;
	logic frame_strobe_reg;
	logic grid_error_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			row_reg <= ROW_FIRST;
			line_cnt_reg <= LINE_CNT_RESET;
			row_strobe_reg <= 1'b0;
			frame_strobe_reg <= 1'b0;
			grid_error_reg <= 1'b0;
		end else if (clk_en) begin
			row_strobe_reg <= commit;
			frame_strobe_reg <= frame_commit;
			if (frame_commit) begin
				row_reg <= ROW_FIRST; // see RL2
				line_cnt_reg <= 8'h01;
				grid_error_reg <= col_reg != words_exp
					|| line_cnt_reg != LINE_CNT_RESET; // see RL1
			end else if (commit) begin
				if (row_reg != LAST_ROW) begin
					row_reg <= row_reg + 8'h01;
				end
				if (line_cnt_reg != 8'hFF) begin
					line_cnt_reg <= line_cnt_reg + 8'h01;
				end
				grid_error_reg <= col_reg != words_exp || row_reg == LAST_ROW; // see RL1
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// drive alternation
	logic pol_int_reg;
	logic drive_pol_reg;
	logic ext_prev_reg;
	logic ext_tog_reg;
	logic alt_fault_reg;
	logic ext_toggle;
	logic use_ext;

	assign ext_toggle = pin_sync[PIN_ALT] != ext_prev_reg;
	// a silent external source would damage the panel; fall back to internal
	assign use_ext = pin_sync[PIN_SEL] && !alt_fault_reg; // see RL6

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pol_int_reg <= 1'b0;
			drive_pol_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			ext_tog_reg <= 1'b0;
			alt_fault_reg <= 1'b0;
		end else if (clk_en) begin
			ext_prev_reg <= pin_sync[PIN_ALT];
			if (commit) begin
				pol_int_reg <= ~pol_int_reg; // see RL5
			end
			drive_pol_reg <= use_ext ? pin_sync[PIN_ALT] : pol_int_reg; // see RL5
			ext_tog_reg <= ext_toggle || (ext_tog_reg && !frame_commit);
			if (frame_commit) begin
				alt_fault_reg <= pin_sync[PIN_SEL] && !ext_tog_reg && !ext_toggle; // see RL6
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// display enable and overrun
	logic display_on_reg;
	logic ovf_prev_reg;
	logic overrun_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			display_on_reg <= 1'b0;
			ovf_prev_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else if (clk_en) begin
			display_on_reg <= pin_sync[PIN_DISP] && mode_cap_reg; // see RL12
			ovf_prev_reg <= pin_sync[PIN_OVF];
			overrun_reg <= (pin_sync[PIN_OVF] != ovf_prev_reg) || (overrun_reg && !frame_commit);
		end
	end

	assign rd_upper = rd_upper_reg;
	assign rd_lower = rd_lower_reg;
	assign scan_row = row_reg;
	assign row_strobe = row_strobe_reg;
	assign frame_strobe = frame_strobe_reg;
	assign drive_polarity = drive_pol_reg;
	assign display_on = display_on_reg;
	assign mode_8bit = mode_reg;
	assign grid_error = grid_error_reg;
	assign alt_fault = alt_fault_reg;
	assign overrun = overrun_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_commit;
		commit;
	endsequence
	sequence s_row_done;
		row_strobe_reg ##1 !row_strobe_reg;
	endsequence

	property p_row_restart;
		frame_commit |=> row_reg == ROW_FIRST && frame_strobe_reg;
	endproperty
	a_row_restart: assert property (p_row_restart) else $error("row not restarted"); // see RL2

	property p_row_advance;
		commit && !frame_at_line_reg && row_reg != LAST_ROW |=> row_reg == $past(row_reg) + 1;
	endproperty
	a_row_advance: assert property (p_row_advance) else $error("row not advanced"); // see RL9

	property p_commit_strobe;
		s_commit |=> s_row_done;
	endproperty
	a_commit_strobe: assert property (p_commit_strobe) else $error("bad row strobe"); // see RL9

	property p_bank_swap;
		commit |=> bank_reg != $past(bank_reg) && col_reg == COL_RESET;
	endproperty
	a_bank_swap: assert property (p_bank_swap) else $error("bank not swapped"); // see RL4

	property p_mask;
		pop && !mode_reg |-> wr_word[15:12] == 4'h0 && wr_word[7:4] == 4'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("upper bits kept"); // see RL11

	property p_grid;
		commit && col_reg != words_exp |=> grid_error_reg;
	endproperty
	a_grid: assert property (p_grid) else $error("short line missed"); // see RL1

	property p_pol_int;
		commit |=> pol_int_reg != $past(pol_int_reg);
	endproperty
	a_pol_int: assert property (p_pol_int) else $error("no internal toggle"); // see RL5

	property p_pol_ext;
		clk_en && use_ext |=> drive_pol_reg == $past(pin_sync[PIN_ALT]);
	endproperty
	a_pol_ext: assert property (p_pol_ext) else $error("external not followed"); // see RL5

	property p_alt_fault;
		frame_commit && pin_sync[PIN_SEL] && !ext_tog_reg && !ext_toggle |=> alt_fault_reg;
	endproperty
	a_alt_fault: assert property (p_alt_fault) else $error("silent alternation missed"); // see RL6

	property p_display;
		clk_en && mode_cap_reg |=> display_on_reg == $past(pin_sync[PIN_DISP]);
	endproperty
	a_display: assert property (p_display) else $error("display enable lost"); // see RL12

	property p_drain_bound;
		state_reg == ST_DRAIN |-> drain_age_reg < 7'(DRAIN_MAX_CYC);
	endproperty
	a_drain_bound: assert property (p_drain_bound) else $error("line latch stuck"); // see RL13

endmodule : dspd_panel

`default_nettype wire

/* tb/dspd_ctrl_model.sv */
// dspd_ctrl_model: behavioural display controller driving the panel link pins.
// assumes one bench process calls its tasks, never two at once.
`default_nettype none

module dspd_ctrl_model
	import dspd_pkg::*;
(
	// panel link pins
	output logic pixel_shift_clock,
	output logic [BUS_WIDTH-1:0] upper_half_data_bus,
	output logic [BUS_WIDTH-1:0] lower_half_data_bus,
	output logic line_latch_clock,
	output logic frame_start_pulse
);
	timeunit 1ns;
	timeprecision 100ps;

	// control pins are low from time zero, ahead of any supply
	initial begin
		pixel_shift_clock = 1'b0;
		upper_half_data_bus = 8'h00;
		lower_half_data_bus = 8'h00;
		line_latch_clock = 1'b0;
		frame_start_pulse = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// bare shift edges, used while the link side comes out of reset
	task automatic pulses(input int n);
		repeat (n) begin
			#40 pixel_shift_clock = 1'b1;
			#40 pixel_shift_clock = 1'b0;
		end
	endtask : pulses

	// one word per edge; buses turn to the inverse once hold has run out
	task automatic shift_word(input logic [7:0] u, input logic [7:0] l);
		#13;
		upper_half_data_bus = u;
		lower_half_data_bus = l;
		#27 pixel_shift_clock = 1'b1;
		#40 pixel_shift_clock = 1'b0;
		upper_half_data_bus = ~u;
		lower_half_data_bus = ~l;
	endtask : shift_word

	// frame start brackets the line clock with setup and hold to spare
	// frame pacing is the caller's; runs far faster than nominal to keep runs short
	task automatic latch_line(input logic first);
		frame_start_pulse = first;
		#200 line_latch_clock = 1'b1;
		#100 line_latch_clock = 1'b0;
		#100 frame_start_pulse = 1'b0;
	endtask : latch_line

endmodule : dspd_ctrl_model

`default_nettype wire

/* tb/dspd_panel_test.sv */
// dspd_panel_test: self-checking bench of the panel receive logic.
// assumes dspd_ctrl_model stands in for the display controller.
`default_nettype none

module dspd_panel_test
	import dspd_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, reset, clk_en, alternation_pin, alt_external_sel;
	logic bus_mode_8bit, display_enable_pin, alt_toggle, int_pol;
	logic [COL_W-1:0] rd_addr;
	wire logic pixel_shift_clock, line_latch_clock, frame_start_pulse;
	wire logic [BUS_WIDTH-1:0] upper_half_data_bus, lower_half_data_bus;
	logic shift_ready, row_strobe, frame_strobe, drive_polarity, display_on;
	logic mode_8bit, grid_error, alt_fault, overrun, got_frame;
	logic [BUS_WIDTH-1:0] rd_upper, rd_lower;
	logic [ROW_W-1:0] scan_row;
	int miscompares, checks, seed, exp_row, lines;
	int exp_u[240];
	int exp_l[240];

	dspd_panel i_dspd_panel (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
		.pixel_shift_clock(pixel_shift_clock), .upper_half_data_bus(upper_half_data_bus),
		.lower_half_data_bus(lower_half_data_bus), .line_latch_clock(line_latch_clock),
		.frame_start_pulse(frame_start_pulse), .alternation_pin(alternation_pin),
		.alt_external_sel(alt_external_sel), .bus_mode_8bit(bus_mode_8bit),
		.display_enable_pin(display_enable_pin), .shift_ready(shift_ready),
		.rd_addr(rd_addr), .rd_upper(rd_upper), .rd_lower(rd_lower), .scan_row(scan_row),
		.row_strobe(row_strobe), .frame_strobe(frame_strobe), .drive_polarity(drive_polarity),
		.display_on(display_on), .mode_8bit(mode_8bit), .grid_error(grid_error),
		.alt_fault(alt_fault), .overrun(overrun));

	dspd_ctrl_model i_dspd_ctrl_model (.pixel_shift_clock(pixel_shift_clock),
		.upper_half_data_bus(upper_half_data_bus), .lower_half_data_bus(lower_half_data_bus),
		.line_latch_clock(line_latch_clock), .frame_start_pulse(frame_start_pulse));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	task automatic cmp_word(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t flag %h exp %h", $time, got, exp);
		end
	endtask : cmp_flag

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cycles

	task automatic wait_row();
		int k;
		got_frame = 1'bx;
		// frame strobe stands one cycle only, so take it with the row strobe
		for (k = 0; k < 300; k++) begin
			cycles(1);
			if (row_strobe === 1'b1) begin
				got_frame = frame_strobe;
				break;
			end
		end
		if (k == 300) miscompares++;
		int_pol = ~int_pol;
	endtask : wait_row

	// link side needs shift edges both in and after reset; first line is a throwaway
	task automatic do_reset(input logic m8);
		reset = 1'b1;
		bus_mode_8bit = m8;
		i_dspd_ctrl_model.pulses(3);
		cycles(20);
		reset = 1'b0;
		int_pol = 1'b0;
		cycles(10);
		i_dspd_ctrl_model.pulses(2);
		fork
			i_dspd_ctrl_model.latch_line(1'b0);
			wait_row();
		join
		// line count starts full at reset; the throwaway line adds one
		lines = ROWS_PER_FRAME + 1;
		cmp_flag(mode_8bit, m8);
		cmp_flag(display_on, 1'b1);
	endtask : do_reset

	task automatic send_row(input int n, input logic first);
		int i, words;
		logic [7:0] u, l;
		logic err;
		words = bus_mode_8bit ? WORDS_8BIT : WORDS_4BIT;
		for (i = 0; i < n; i++) begin
			u = 8'($random(seed));
			l = 8'($random(seed));
			if (!bus_mode_8bit) begin
				u &= 8'h0f;
				l &= 8'h0f;
			end
			exp_u[i] = u;
			exp_l[i] = l;
			i_dspd_ctrl_model.shift_word(u, l);
		end
		if (!clk_en) begin
			cmp_flag(shift_ready, 1'b0);
			clk_en = 1'b1;
		end
		if (alt_external_sel && alt_toggle) alternation_pin = ~alternation_pin;
		fork
			i_dspd_ctrl_model.latch_line(first);
			wait_row();
		join
		err = (n != words) || (first && lines != ROWS_PER_FRAME);
		exp_row = first ? 0 : (exp_row < 239 ? exp_row + 1 : 239);
		lines = first ? 1 : lines + 1;
		cmp_word(scan_row, 8'(exp_row));
		cmp_flag(got_frame, first);
		cmp_flag(grid_error, err);
		if (!alt_external_sel) cmp_flag(drive_polarity, int_pol);
		else if (alt_toggle) cmp_flag(drive_polarity, alternation_pin);
	endtask : send_row

	task automatic check_row(input int n);
		int a;
		for (a = 0; a <= n; a++) begin
			rd_addr = (a == n) ? 8'hF0 : 8'(a);
			cycles(1);
			cmp_word(rd_upper, (a == n) ? 8'h00 : 8'(exp_u[a]));
			cmp_word(rd_lower, (a == n) ? 8'h00 : 8'(exp_l[a]));
		end
	endtask : check_row

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 30;
		miscompares = 0;
		checks = 0;
		reset = 1'b1;
		clk_en = 1'b1;
		rd_addr = 8'h00;
		alternation_pin = 1'b0;
		alt_external_sel = 1'b0;
		alt_toggle = 1'b1;
		bus_mode_8bit = 1'b1;
		display_enable_pin = 1'b1;
		lines = 0;
		exp_row = 0;
		do_reset(1'b1);
		send_row(WORDS_8BIT, 1'b1);
		check_row(WORDS_8BIT);
		repeat (3) send_row(2, 1'b0);
		display_enable_pin = 1'b0;
		cycles(6);
		cmp_flag(display_on, 1'b0);
		display_enable_pin = 1'b1;
		cycles(6);
		cmp_flag(display_on, 1'b1);
		alt_external_sel = 1'b1;
		send_row(2, 1'b0);
		send_row(2, 1'b1);
		cmp_flag(alt_fault, 1'b0);
		alt_toggle = 1'b0;
		send_row(2, 1'b0);
		send_row(2, 1'b1);
		cmp_flag(alt_fault, 1'b1);
		alt_external_sel = 1'b0;
		// drain frozen so twenty words overflow the sixteen-word buffer
		clk_en = 1'b0;
		send_row(20, 1'b0);
		cmp_flag(overrun, 1'b1);
		do_reset(1'b0);
		send_row(WORDS_4BIT, 1'b1);
		check_row(WORDS_4BIT);
		cmp_flag(overrun, 1'b0);
		print_verdict();
	end

	initial begin
		#300us;
		miscompares++;
		print_verdict();
	end

endmodule : dspd_panel_test

`default_nettype wire
